// File: rtl/adcts_consts.svh
// Purpose: shared offsets, field positions, reset values and codes
// Assumes: 20-bit byte addresses on the register port
// Notes:   definitions only
`ifndef ADCTS_CONSTS_SVH
`define ADCTS_CONSTS_SVH

`define ADCTS_ADDR_W        20
`define ADCTS_DATA_W        16
`define ADCTS_OFF_ADDCNT    20'h8_900c
`define ADCTS_OFF_EXTCTL    20'h8_900e
`define ADCTS_OFF_TRIG      20'h8_9010
`define ADCTS_OFF_INTSRC    20'h8_9012
`define ADCTS_OFF_SST0      20'h8_9060
`define ADCTS_OFF_SSTH      20'h8_9061
`define ADCTS_OFF_SSTT      20'h8_9070
`define ADCTS_OFF_SSTV      20'h8_9071
`define ADCTS_OFF_SST1      20'h8_9073
`define ADCTS_OFF_SST2      20'h8_9074
`define ADCTS_OFF_SST3      20'h8_9075
`define ADCTS_OFF_SST4      20'h8_9076
`define ADCTS_OFF_SST6      20'h8_9078
`define ADCTS_OFF_SCANCTL   20'h8_9080

`define ADCTS_MASK_ADDCNT   16'h0003
`define ADCTS_MASK_EXTCTL   16'h8020
`define ADCTS_MASK_TRIG     16'h0f0f
`define ADCTS_MASK_INTSRC   16'h0303
`define ADCTS_MASK_SCANCTL  16'h003f

`define ADCTS_BIT_ACE       5
`define ADCTS_BIT_FMT       15
`define ADCTS_LSB_TRSB      0
`define ADCTS_LSB_TRSA      8
`define ADCTS_BIT_TEMP_SUM_SEL     0
`define ADCTS_BIT_VREF_SUM_SEL     1
`define ADCTS_BIT_TSS       8
`define ADCTS_BIT_OCS       9
`define ADCTS_BIT_GO        0
`define ADCTS_BIT_HWEN      1
`define ADCTS_BIT_PINSEL    2
`define ADCTS_LSB_MODE      3
`define ADCTS_BIT_DUP       5

`define ADCTS_SST_RESET     8'h14
`define ADCTS_SST_NUM       9
`define ADCTS_SST_CH6       4'h5
`define ADCTS_SST_HIGH      4'h6
`define ADCTS_SST_TEMP      4'h7
`define ADCTS_SST_VREF      4'h8

`define ADCTS_MODE_SINGLE   2'h0
`define ADCTS_MODE_GROUP    2'h1
`define ADCTS_MODE_CONT     2'h2

`define ADCTS_TRIG_NUM      9
`define ADCTS_TRIG_NONE     4'h0
`define ADCTS_TRIG_MAX      4'h9

`define ADCTS_ITEMS         19
`define ADCTS_CH_MASK       16'hff5f
`define ADCTS_ITEM_DUP      19'h1_0000
`define ADCTS_ITEM_TEMP     19'h2_0000
`define ADCTS_ITEM_VREF     19'h4_0000
`define ADCTS_IDX_DUP       5'h10
`define ADCTS_IDX_TEMP      5'h11
`define ADCTS_IDX_VREF      5'h12
`define ADCTS_SRC_TEMP      5'h10
`define ADCTS_SRC_VREF      5'h11

`endif

// File: rtl/adcts_pkg.sv
// Purpose: types of the trigger and sampling control block
// Assumes: constants come from adcts_consts.svh
// Notes:   state encoding left to the tool
package adcts_pkg;
    typedef enum logic [1:0] {
        ADCTS_ST_IDLE,
        ADCTS_ST_PICK,
        ADCTS_ST_SAMPLE,
        ADCTS_ST_CONV
    } adcts_state_t;
endpackage

// File: rtl/adcts_state_timer.sv
// Purpose: counts sampling states of the conversion clock
// Assumes: one state is one clock_i cycle
// Notes:   run_o stays high for states_i plus one cycles
`timescale 1ns/100ps
module adcts_state_timer #(
    parameter int W = 8
) (
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    input  wire logic         start_i,
    input  wire logic [W-1:0] states_i,
    output logic              run_o,
    output logic              done_o
);
    logic [W-1:0] cnt_ff;
    logic         run_ff;

    assign done_o = run_ff && (cnt_ff == '0);
    assign run_o  = run_ff;

    // programmed count plus one extra state
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
        end else if (start_i) begin
            cnt_ff <= states_i;
            run_ff <= 1'b1;
        end else if (done_o) begin
            run_ff <= 1'b0;
        end else if (run_ff) begin
            cnt_ff <= cnt_ff - W'(1);
        end
    end
endmodule

// File: rtl/adcts_top.sv
// Purpose: trigger selection, addition, alignment and sampling time control
// Assumes: triggers and pin are synchronous to clock_i; one state = one cycle
// Notes:   result storage lives outside; this block writes and clears it
// Function
// - addition code selects one to four conversions
// - one addition count for all sources
// - auto clear zeroes result after read
// - format bit selects right or left alignment
// - added results always stored left aligned
// - group B trigger field starts group B
// - primary trigger field starts single, continuous, group A
// - software start works regardless of trigger setup
// - trigger codes map to nine timer/event sources
// - sensor and reference addition store the sum
// - temperature select converts sensor in single scan
// - reference select converts internal reference, single scan
// - sampling fields hold 6 to 255 states; the fields store any 8-bit value, 0 to 255
// - sample programmed states plus one; reset 20
// - separate sampling fields per channel group
// - reserved bits read zero
// - triggers ignored while a scan runs
`timescale 1ns/100ps
`include "adcts_consts.svh"
module adcts_top
    import adcts_pkg::*;
(
    input  wire logic                       clock_i,
    input  wire logic                       rst_n_i,
    input  wire logic [`ADCTS_ADDR_W-1:0]   reg_addr_i,
    input  wire logic [`ADCTS_DATA_W-1:0]   reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic      [`ADCTS_DATA_W-1:0]   reg_rdata_o,
    input  wire logic [15:0]                group_a_channels_i,
    input  wire logic [15:0]                group_b_channels_i,
    input  wire logic [15:0]                sum_channels_i,
    input  wire logic [4:0]                 dup_channel_sel_i,
    input  wire logic [`ADCTS_TRIG_NUM-1:0] trig_src_i,
    input  wire logic                       ext_trigger_pin_n_i,
    output logic                            sampling_o,
    output logic      [4:0]                 sample_src_o,
    output logic                            conv_start_o,
    input  wire logic                       conv_done_i,
    input  wire logic [11:0]                conv_data_i,
    output logic                            result_wr_o,
    output logic      [4:0]                 result_idx_o,
    output logic      [15:0]                result_data_o,
    input  wire logic                       result_read_i,
    input  wire logic [4:0]                 result_read_idx_i,
    output logic                            result_clear_o,
    output logic      [4:0]                 result_clear_idx_o,
    output logic                            busy_o
);
    // ---------------- registers ----------------
    logic [1:0]  addcnt_ff;
    logic        ace_ff;
    logic        fmt_ff;
    logic [3:0]  trsb_ff;
    logic [3:0]  trsa_ff;
    logic        temp_sum_sel_ff;
    logic        vref_sum_sel_ff;
    logic        tss_ff;
    logic        ocs_ff;
    logic [7:0]  sst_ff [`ADCTS_SST_NUM];
    logic        hwen_ff;
    logic        pinsel_ff;
    logic [1:0]  mode_ff;
    logic        dup_en_ff;
    logic        go_ff;
    logic [15:0] rdata_ff;

    // ---------------- sequencing state ----------------
    adcts_state_t               state_ff;
    adcts_state_t               nxt_state;
    logic [`ADCTS_ITEMS-1:0]    pending_ff;
    logic [`ADCTS_ITEMS-1:0]    nxt_pending;
    logic [4:0]                 item_ff;
    logic [4:0]                 nxt_item;
    logic [1:0]                 rep_ff;
    logic [1:0]                 nxt_rep;
    logic [13:0]                acc_ff;
    logic [13:0]                nxt_acc;
    logic                       nxt_go;
    logic                       grp_b_ff;
    logic                       nxt_grp_b;
    logic                       dup_sync_ff;
    logic                       nxt_dup_sync;
    logic                       dup_second_ff;
    logic                       pin_prev_ff;
    logic [4:0]                 src_ff;
    logic                       res_wr_ff;
    logic [4:0]                 res_idx_ff;
    logic [15:0]                res_data_ff;
    logic                       clr_ff;
    logic [4:0]                 clr_idx_ff;
    logic                       tmr_start;
    logic                       tmr_done;
    logic                       store;

    // ---------------- helpers ----------------
    function automatic logic [4:0] lowest_item(input logic [`ADCTS_ITEMS-1:0] m);
        logic [4:0] r;
        r = 5'h00;
        for (int i = `ADCTS_ITEMS - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    // only codes 1..9 reach a source
    function automatic logic trig_hit(input logic [3:0] code,
                                      input logic [`ADCTS_TRIG_NUM-1:0] src);
        logic [3:0] k;
        k = code - 4'h1;
        if (code == `ADCTS_TRIG_NONE || code > `ADCTS_TRIG_MAX) begin
            return 1'b0;
        end
        return src[k];
    endfunction

    // sampling field that serves an item
    function automatic logic [3:0] sst_of(input logic [4:0] it, input logic [4:0] dch);
        logic [4:0] ch;
        ch = (it == `ADCTS_IDX_DUP) ? dch : it;
        if (it == `ADCTS_IDX_TEMP) begin
            return `ADCTS_SST_TEMP;
        end
        if (it == `ADCTS_IDX_VREF) begin
            return `ADCTS_SST_VREF;
        end
        if (ch[4] || ch[3]) begin
            return `ADCTS_SST_HIGH;
        end
        if (ch == 5'h06) begin
            return `ADCTS_SST_CH6;
        end
        return ch[3:0];
    endfunction

    // ---------------- register decode ----------------
    wire hit_addcnt  = reg_addr_i == `ADCTS_OFF_ADDCNT;
    wire hit_extctl  = reg_addr_i == `ADCTS_OFF_EXTCTL;
    wire hit_trig    = reg_addr_i == `ADCTS_OFF_TRIG;
    wire hit_intsrc  = reg_addr_i == `ADCTS_OFF_INTSRC;
    wire hit_scanctl = reg_addr_i == `ADCTS_OFF_SCANCTL;
    wire [3:0] sst_idx =
        (reg_addr_i == `ADCTS_OFF_SST0) ? 4'h0 :
        (reg_addr_i == `ADCTS_OFF_SST1) ? 4'h1 :
        (reg_addr_i == `ADCTS_OFF_SST2) ? 4'h2 :
        (reg_addr_i == `ADCTS_OFF_SST3) ? 4'h3 :
        (reg_addr_i == `ADCTS_OFF_SST4) ? 4'h4 :
        (reg_addr_i == `ADCTS_OFF_SST6) ? `ADCTS_SST_CH6 :
        (reg_addr_i == `ADCTS_OFF_SSTH) ? `ADCTS_SST_HIGH :
        (reg_addr_i == `ADCTS_OFF_SSTT) ? `ADCTS_SST_TEMP :
        (reg_addr_i == `ADCTS_OFF_SSTV) ? `ADCTS_SST_VREF : 4'hf;
    wire hit_sst = sst_idx != 4'hf;
    wire [15:0] wmask_d = reg_wdata_i;

    wire [15:0] rd_addcnt  = {14'h0000, addcnt_ff};
    wire [15:0] rd_extctl  = {fmt_ff, 9'h000, ace_ff, 5'h00};
    wire [15:0] rd_trig    = {4'h0, trsa_ff, 4'h0, trsb_ff};
    wire [15:0] rd_intsrc  = {6'h00, ocs_ff, tss_ff, 6'h00, vref_sum_sel_ff, temp_sum_sel_ff};
    wire [15:0] rd_scanctl = {10'h000, dup_en_ff, mode_ff, pinsel_ff, hwen_ff, go_ff};
    wire [15:0] rd_val =
        hit_addcnt  ? rd_addcnt  :
        hit_extctl  ? rd_extctl  :
        hit_trig    ? rd_trig    :
        hit_intsrc  ? rd_intsrc  :
        hit_scanctl ? rd_scanctl :
        hit_sst     ? {8'h00, sst_ff[sst_idx]} : 16'h0000;

    // ---------------- start sources ----------------
    wire sw_ctl   = reg_wr_i && hit_scanctl;
    wire sw_go    = sw_ctl && wmask_d[`ADCTS_BIT_GO];
    wire sw_stop  = sw_ctl && !wmask_d[`ADCTS_BIT_GO];
    wire pin_fall = pin_prev_ff && !ext_trigger_pin_n_i;
    wire sync_a   = hwen_ff && !pinsel_ff && trig_hit(trsa_ff, trig_src_i);
    wire pin_a    = hwen_ff && pinsel_ff && (trsa_ff == `ADCTS_TRIG_NONE)
                    && pin_fall;
    wire sync_b   = hwen_ff && (mode_ff == `ADCTS_MODE_GROUP)
                    && trig_hit(trsb_ff, trig_src_i);
    wire idle     = !go_ff;
    wire start_a  = idle && (sw_go || sync_a || pin_a);
    wire start_b  = idle && !start_a && sync_b;

    wire single   = mode_ff == `ADCTS_MODE_SINGLE;
    wire [`ADCTS_ITEMS-1:0] load_a =
        (tss_ff && single) ? `ADCTS_ITEM_TEMP :
        (ocs_ff && single) ? `ADCTS_ITEM_VREF :
        (dup_en_ff && mode_ff != `ADCTS_MODE_CONT) ? `ADCTS_ITEM_DUP :
        {3'b000, group_a_channels_i & `ADCTS_CH_MASK};
    wire [`ADCTS_ITEMS-1:0] load_b = {3'b000, group_b_channels_i & `ADCTS_CH_MASK};

    // ---------------- per item settings ----------------
    wire [4:0] low_item = lowest_item(pending_ff);
    wire [4:0] pick_item = (state_ff == ADCTS_ST_PICK) ? low_item : item_ff;
    wire [3:0] sst_sel = sst_of(pick_item, dup_channel_sel_i);
    wire [4:0] pick_src =
        (low_item == `ADCTS_IDX_TEMP) ? `ADCTS_SRC_TEMP :
        (low_item == `ADCTS_IDX_VREF) ? `ADCTS_SRC_VREF :
        (low_item == `ADCTS_IDX_DUP)  ? dup_channel_sel_i : low_item;
    wire sum_mode =
        (item_ff == `ADCTS_IDX_TEMP) ? temp_sum_sel_ff :
        (item_ff == `ADCTS_IDX_VREF) ? vref_sum_sel_ff :
        (item_ff == `ADCTS_IDX_DUP)  ? sum_channels_i[dup_channel_sel_i[3:0]] :
        sum_channels_i[item_ff[3:0]];
    wire [1:0]  reps     = sum_mode ? addcnt_ff : 2'b00;
    wire [13:0] total    = acc_ff + {2'b00, conv_data_i};
    wire        last_rep = rep_ff == reps;
    wire [15:0] aligned  =
        sum_mode ? {total, 2'b00} :
        fmt_ff   ? {conv_data_i, 4'h0} : {4'h0, conv_data_i};
    wire to_dup = dup_sync_ff && dup_second_ff;
    wire [4:0] store_idx =
        (item_ff != `ADCTS_IDX_DUP) ? item_ff :
        to_dup ? `ADCTS_IDX_DUP : dup_channel_sel_i;

    assign store        = (state_ff == ADCTS_ST_CONV) && conv_done_i && last_rep;
    assign tmr_start    = ((state_ff == ADCTS_ST_PICK) && (pending_ff != '0)) ||
                          ((state_ff == ADCTS_ST_CONV) && conv_done_i && !last_rep);
    assign conv_start_o = (state_ff == ADCTS_ST_SAMPLE) && tmr_done;

    // ---------------- sequencer ----------------
    always_comb begin
        nxt_state    = state_ff;
        nxt_pending  = pending_ff;
        nxt_item     = item_ff;
        nxt_rep      = rep_ff;
        nxt_acc      = acc_ff;
        nxt_go       = go_ff;
        nxt_grp_b    = grp_b_ff;
        nxt_dup_sync = dup_sync_ff;
        case (state_ff)
            ADCTS_ST_IDLE: begin
                if (start_a || start_b) begin
                    nxt_pending  = start_a ? load_a : load_b;
                    nxt_grp_b    = start_b;
                    nxt_dup_sync = start_a && sync_a && !sw_go;
                    nxt_go       = 1'b1;
                    nxt_state    = ADCTS_ST_PICK;
                end
            end
            ADCTS_ST_PICK: begin
                if (pending_ff != '0) begin
                    nxt_item  = low_item;
                    nxt_rep   = 2'b00;
                    nxt_acc   = 14'h0000;
                    nxt_state = ADCTS_ST_SAMPLE;
                end else if (mode_ff == `ADCTS_MODE_CONT && !grp_b_ff) begin
                    nxt_pending = load_a;
                end else begin
                    nxt_go    = 1'b0;
                    nxt_state = ADCTS_ST_IDLE;
                end
            end
            ADCTS_ST_SAMPLE: begin
                if (tmr_done) begin
                    nxt_state = ADCTS_ST_CONV;
                end
            end
            ADCTS_ST_CONV: begin
                if (conv_done_i) begin
                    nxt_acc = total;
                    if (last_rep) begin
                        nxt_pending = pending_ff & ~(`ADCTS_ITEMS'(1) << item_ff);
                        nxt_state   = ADCTS_ST_PICK;
                    end else begin
                        nxt_rep   = rep_ff + 2'b01;
                        nxt_state = ADCTS_ST_SAMPLE;
                    end
                end
            end
            default: begin
                nxt_state = ADCTS_ST_IDLE;
            end
        endcase
        if (sw_stop) begin
            nxt_state   = ADCTS_ST_IDLE;
            nxt_pending = '0;
            nxt_go      = 1'b0;
        end
    end

    adcts_state_timer #(
        .W (8)
    ) u_timer (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .start_i  (tmr_start),
        .states_i (sst_ff[sst_sel]),
        .run_o    (sampling_o),
        .done_o   (tmr_done)
    );

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff    <= ADCTS_ST_IDLE;
            pending_ff  <= '0;
            item_ff     <= 5'h00;
            rep_ff      <= 2'b00;
            acc_ff      <= 14'h0000;
            go_ff       <= 1'b0;
            grp_b_ff    <= 1'b0;
            dup_sync_ff <= 1'b0;
            pin_prev_ff <= 1'b1;
            src_ff      <= 5'h00;
        end else begin
            state_ff    <= nxt_state;
            pending_ff  <= nxt_pending;
            item_ff     <= nxt_item;
            rep_ff      <= nxt_rep;
            acc_ff      <= nxt_acc;
            go_ff       <= nxt_go;
            grp_b_ff    <= nxt_grp_b;
            dup_sync_ff <= nxt_dup_sync;
            pin_prev_ff <= ext_trigger_pin_n_i;
            if (state_ff == ADCTS_ST_PICK) begin
                src_ff <= pick_src;
            end
        end
    end

    // duplication alternates channel and duplicate register per sync scan
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dup_second_ff <= 1'b0;
        end else if (!dup_en_ff) begin
            dup_second_ff <= 1'b0;
        end else if (store && item_ff == `ADCTS_IDX_DUP && dup_sync_ff) begin
            dup_second_ff <= !dup_second_ff;
        end
    end

    // result write and clear-on-read strobes
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            res_wr_ff   <= 1'b0;
            res_idx_ff  <= 5'h00;
            res_data_ff <= 16'h0000;
            clr_ff      <= 1'b0;
            clr_idx_ff  <= 5'h00;
        end else begin
            res_wr_ff  <= store;
            clr_ff     <= result_read_i && ace_ff;
            clr_idx_ff <= result_read_idx_i;
            if (store) begin
                res_idx_ff  <= store_idx;
                res_data_ff <= aligned;
            end
        end
    end

    // software register file; reserved bits are never stored
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addcnt_ff <= 2'b00;
            ace_ff    <= 1'b0;
            fmt_ff    <= 1'b0;
            trsb_ff   <= 4'h0;
            trsa_ff   <= 4'h0;
            temp_sum_sel_ff  <= 1'b0;
            vref_sum_sel_ff  <= 1'b0;
            tss_ff    <= 1'b0;
            ocs_ff    <= 1'b0;
            hwen_ff   <= 1'b0;
            pinsel_ff <= 1'b0;
            mode_ff   <= `ADCTS_MODE_SINGLE;
            dup_en_ff <= 1'b0;
            rdata_ff  <= 16'h0000;
            for (int i = 0; i < `ADCTS_SST_NUM; i++) begin
                sst_ff[i] <= `ADCTS_SST_RESET;
            end
        end else begin
            rdata_ff <= reg_rd_i ? rd_val : 16'h0000;
            if (reg_wr_i && hit_addcnt) begin
                addcnt_ff <= wmask_d[1:0];
            end
            if (reg_wr_i && hit_extctl) begin
                ace_ff <= wmask_d[`ADCTS_BIT_ACE];
                fmt_ff <= wmask_d[`ADCTS_BIT_FMT];
            end
            if (reg_wr_i && hit_trig) begin
                trsb_ff <= wmask_d[`ADCTS_LSB_TRSB +: 4];
                trsa_ff <= wmask_d[`ADCTS_LSB_TRSA +: 4];
            end
            if (reg_wr_i && hit_intsrc) begin
                temp_sum_sel_ff <= wmask_d[`ADCTS_BIT_TEMP_SUM_SEL];
                vref_sum_sel_ff <= wmask_d[`ADCTS_BIT_VREF_SUM_SEL];
                tss_ff   <= wmask_d[`ADCTS_BIT_TSS];
                ocs_ff   <= wmask_d[`ADCTS_BIT_OCS];
            end
            if (sw_ctl) begin
                hwen_ff   <= wmask_d[`ADCTS_BIT_HWEN];
                pinsel_ff <= wmask_d[`ADCTS_BIT_PINSEL];
                mode_ff   <= wmask_d[`ADCTS_LSB_MODE +: 2];
                dup_en_ff <= wmask_d[`ADCTS_BIT_DUP];
            end
            if (reg_wr_i && hit_sst) begin
                sst_ff[sst_idx] <= wmask_d[7:0];
            end
        end
    end

    assign reg_rdata_o        = rdata_ff;
    assign sample_src_o       = src_ff;
    assign result_wr_o        = res_wr_ff;
    assign result_idx_o       = res_idx_ff;
    assign result_data_o      = res_data_ff;
    assign result_clear_o     = clr_ff;
    assign result_clear_idx_o = clr_idx_ff;
    assign busy_o             = go_ff;
endmodule

// File: verification/adcts_checker.sv
// Purpose: port rules of the trigger and sampling block
// Assumes: sampling fields of 6 or more
// Notes:   bound to adcts_top
`timescale 1ns/100ps
module adcts_checker (
    input wire logic        clock_i, rst_n_i, reg_rd_i, sampling_o, conv_start_o,
    input wire logic        conv_done_i, result_wr_o, result_read_i, result_clear_o, busy_o,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [4:0]  sample_src_o, result_read_idx_i, result_clear_idx_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data outside answer");
    a_clear_cause: assert property (result_clear_o |-> $past(result_read_i)
        && result_clear_idx_o == $past(result_read_idx_i)) else $error("bad clear");
    a_sample_end: assert property (conv_start_o |-> sampling_o ##1 !sampling_o)
        else $error("start not at end");
    a_sample_min: assert property ($rose(sampling_o) |-> sampling_o [*7])
        else $error("sampling short");
    a_start_answer: assert property ($rose(busy_o) |-> ##1 $rose(sampling_o))
        else $error("scan not begun");
    a_sample_busy: assert property (sampling_o |-> busy_o)
        else $error("sampling idle");
    a_store_after: assert property (result_wr_o |-> $past(conv_done_i) && busy_o)
        else $error("store without conversion");
    a_src_legal: assert property (sampling_o |-> sample_src_o <= 5'h11
        && sample_src_o != 5'h05 && sample_src_o != 5'h07) else $error("bad source");
    c_scan: cover property ($rose(busy_o));
    c_clear: cover property (result_clear_o);
    c_store: cover property (result_wr_o);
endmodule
bind adcts_top adcts_checker u_chk (.clock_i, .rst_n_i, .reg_rd_i, .sampling_o,
    .conv_start_o, .conv_done_i, .result_wr_o, .result_read_i, .result_clear_o, .busy_o,
    .reg_rdata_o, .sample_src_o, .result_read_idx_i, .result_clear_idx_o);

// File: verification/adcts_core_model.sv
// Purpose: analog core stand-in, answers a conversion after a lag
// Assumes: start_i is a one-cycle pulse
// Notes:   data toggles outside the answer
`timescale 1ns/100ps
module adcts_core_model (
    input  wire logic        clock_i,
    input  wire logic        start_i,
    input  wire logic [11:0] value_i,
    input  wire logic [2:0]  lag_i,
    output logic             done_o,
    output logic [11:0]      data_o
);
    int cnt = -1;
    initial begin
        done_o = 0;
        data_o = 0;
    end
    always @(posedge clock_i) begin
        done_o <= 0;
        data_o <= ~data_o;
        if (start_i) cnt <= int'(lag_i);
        else if (cnt > 0) cnt <= cnt - 1;
        else if (cnt == 0) begin
            done_o <= 1;
            data_o <= value_i;
            cnt    <= -1;
        end
    end
endmodule

// File: verification/adc_trigger_sampling_config_test.sv
// Purpose: self-checking bench of the trigger and sampling block
// Assumes: core model answers after a random lag
// Notes:   expectations built per scan from integers
`timescale 1ns/100ps
`include "adcts_consts.svh"
module adc_trigger_sampling_config_test;
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin fails++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
    logic        clock_i = 0, rst_n_i = 0, wr = 0, rd = 0, rr = 0, dn, smp, cs, rw, clr, busy;
    logic [8:0]  trg = 0;
    logic [4:0]  rri = 0, ridx, cidx, gidx;
    logic [11:0] val = 0, cd, v;
    logic [2:0]  lag = 0;
    logic [15:0] wd = 0, ga = 0, sm = 0, rdat, rdt, gdat, ex;
    logic [19:0] a = 0;
    int          fails = 0, total_checks = 0, scnt, n, sb, s, c, k, tot;
    int          chs [15] = '{0, 1, 2, 3, 4, 6, 8, 9, 10, 11, 12, 13, 14, 15, 16};
    adcts_top DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(a), .reg_wdata_i(wd),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .group_a_channels_i(ga),
        .group_b_channels_i(16'h0000), .sum_channels_i(sm), .dup_channel_sel_i(5'h00),
        .trig_src_i(trg), .ext_trigger_pin_n_i(1'b1), .sampling_o(smp), .sample_src_o(),
        .conv_start_o(cs), .conv_done_i(dn), .conv_data_i(cd), .result_wr_o(rw),
        .result_idx_o(ridx), .result_data_o(rdt), .result_read_i(rr),
        .result_read_idx_i(rri), .result_clear_o(clr), .result_clear_idx_o(cidx),
        .busy_o(busy));
    adcts_core_model core (.clock_i(clock_i), .start_i(cs), .value_i(val), .lag_i(lag),
        .done_o(dn), .data_o(cd));
    initial forever #5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        if (smp) scnt <= scnt + 1;
        if (rw) begin
            gidx <= ridx;
            gdat <= rdt;
        end
    end
    function automatic logic [19:0] sst(input int ch);
        if (ch == 16) return `ADCTS_OFF_SSTT;
        if (ch >= 8) return `ADCTS_OFF_SSTH;
        if (ch == 6) return `ADCTS_OFF_SST6;
        return ch == 0 ? `ADCTS_OFF_SST0 : `ADCTS_OFF_SST1 + 20'(ch - 1);
    endfunction
    task wr_reg(input logic [19:0] ad, input logic [15:0] d);
        @(posedge clock_i);
        a <= ad; wd <= d; wr <= 1;
        @(posedge clock_i);
        wr <= 0;
    endtask
    task rd_chk(input logic [19:0] ad, input logic [15:0] e);
        @(posedge clock_i);
        a <= ad; rd <= 1;
        @(posedge clock_i);
        rd <= 0;
        #1 `CHK("rdata", e, rdat)
    endtask
    task pulse(input logic [8:0] p);
        @(posedge clock_i);
        trg <= p;
        @(posedge clock_i);
        trg <= 0;
        @(posedge clock_i);
        #1;
    endtask
    task wait_idle;
        #1;
        for (k = 0; k < 4000 && busy !== 1'b0; k++) begin
            @(posedge clock_i);
            #1;
        end
        `CHK("idle", 1'b0, busy)
        @(posedge clock_i);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #500_000;
        fails++;
        give_verdict;
    end
    initial begin
        void'($urandom(73776));
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1;
        foreach (chs[i]) rd_chk(sst(chs[i]), 16'h0014);
        rd_chk(20'h8_9000, 16'h0000);
        wr_reg(`ADCTS_OFF_TRIG, 16'hffff);
        rd_chk(`ADCTS_OFF_TRIG, 16'h0f0f);
        wr_reg(`ADCTS_OFF_INTSRC, 16'hffff);
        rd_chk(`ADCTS_OFF_INTSRC, 16'h0303);
        $display("test registers done");
        for (int i = 0; i < 10; i++) begin
            c = chs[$urandom % 15];
            s = 6 + $urandom % 20;
            sb = $urandom % 2;
            n = sb ? 1 + $urandom % 3 : $urandom % 4;
            k = $urandom % 2;
            v = 12'($urandom);
            wr_reg(sst(c), 16'(s));
            wr_reg(`ADCTS_OFF_ADDCNT, 16'(n));
            wr_reg(`ADCTS_OFF_EXTCTL, k ? 16'h8000 : 16'h0000);
            wr_reg(`ADCTS_OFF_INTSRC, c == 16 ? 16'(16'h0100 + sb) : 16'h0000);
            ga <= 16'h0001 << c;
            sm <= 16'(sb) << c;
            val <= v;
            lag <= 3'($urandom);
            scnt = 0;
            tot = (sb ? n + 1 : 1) * v;
            ex = sb ? {tot[13:0], 2'b00} : k ? {v, 4'h0} : {4'h0, v};
            wr_reg(`ADCTS_OFF_SCANCTL, 16'h0001 | 16'($urandom % 4) << 1);
            wait_idle;
            `CHK("samples", (sb ? n + 1 : 1) * (s + 1), scnt)
            `CHK("index", c == 16 ? 5'h11 : 5'(c), gidx)
            `CHK("result", ex, gdat)
        end
        $display("test conversions done");
        wr_reg(`ADCTS_OFF_INTSRC, 16'h0000);
        wr_reg(sst(0), 16'h0006);
        wr_reg(`ADCTS_OFF_SCANCTL, 16'h0002);
        ga <= 16'h0001;
        sm <= 16'h0000;
        for (c = 1; c < 16; c++) begin
            wr_reg(`ADCTS_OFF_TRIG, 16'(c) << 8);
            pulse(c < 10 ? ~(9'h001 << (c - 1)) : 9'h1ff);
            `CHK("no start", 1'b0, busy)
            if (c < 10) begin
                scnt = 0;
                pulse(9'h001 << (c - 1));
                `CHK("started", 1'b1, busy)
                pulse(9'h001 << (c - 1));
                wait_idle;
                `CHK("one scan", 7, scnt)
            end
        end
        $display("test triggers done");
        wr_reg(`ADCTS_OFF_EXTCTL, 16'h0020);
        @(posedge clock_i);
        rr <= 1; rri <= 5'h03;
        @(posedge clock_i);
        rr <= 0;
        #1 `CHK("clear", 2'b11, {clr, cidx == 5'h03})
        wr_reg(`ADCTS_OFF_EXTCTL, 16'h0000);
        rr <= 1;
        @(posedge clock_i);
        rr <= 0;
        #1 `CHK("no clear", 1'b0, clr)
        $display("test auto clear done");
        give_verdict;
    end
endmodule
